// ==== rtl/output_pwm_ctrl.sv ====
`timescale 1ns/100ps
`include "pwm_ctrl_params.svh"
// Function
// - Supply undervoltage forces all outputs high impedance, sets fault summary.
// - Fault summary is the OR of overcurrent, overvoltage and undervoltage.
// - Undervoltage also sets the dedicated undervoltage flag.
// - Latch select 0: outputs resume automatically once supply recovers.
// - Latch select 1: outputs stay off until flags are cleared.
// - Standby keeps pump off; active mode starts oscillator and pump.
// - Drivers stay disabled after going active until delay expires.
// - Delay counts from chip select high, at most 400 us.
// - Half-bridge and heater outputs gate on state with PWM when enabled.
// - Fixed PWM source per output; even lamps use input b.
// - Each lamp selects 170 Hz or 225 Hz internally.
// - Internal duty is 7-bit or 10-bit by resolution select.
// - Source select chooses internal or external, resets to external.
// - Each output owns an overcurrent retry enable.
// - Retry re-enables output after recovery time, repeating while faulty.
// - Recovery time selectable, except lamps 1 and 2 in bulb mode use fixed time.
// - Clearing retry during overload latches the output off.
// - Control and status survive loss of power-stage supply.
// - Supply flags clear only by read-and-clear of status two.
module output_pwm_ctrl
(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // Serial port framing
    input  wire logic                   chip_select_n,
    // Mode and supply control
    input  wire logic                   mode_active,
    input  wire logic                   supply_fault_latch_select,
    input  wire logic                   status2_read_clear,
    // Supply monitors (filtered, asynchronous)
    input  wire logic                   supply_uv_in,
    input  wire logic                   supply_ov_in,
    // PWM pins
    input  wire logic                   pwm_input_a,
    input  wire logic                   sense_out_pwm_input_b,
    // Output control
    input  wire logic [`NUM_OUT-1:0]    out_on,
    input  wire logic [`NUM_OUT-1:0]    output_pwm_enable,
    input  wire logic [`NUM_OUT-1:0]    overcurrent_retry_enable,
    input  wire logic [`NUM_OUT-1:0]    recovery_slow_select,
    input  wire logic [`NUM_OUT-1:0]    oc_status_clear,
    input  wire logic [`NUM_OUT-1:0]    overcurrent_in,
    // Internal generator
    input  wire logic                   pwm_source_internal_select,
    input  wire logic                   duty_resolution_select,
    input  wire logic [`NUM_LAMP-1:0]   pwm_frequency_select,
    input  wire logic [`NUM_LAMP-1:0]   lamp_led_mode,
    input  wire pwm_ctrl_pkg::duty_t    duty_value [`NUM_LAMP],
    // Drive and status
    output logic [`NUM_OUT-1:0]         out_drive,
    output logic [`NUM_OUT-1:0]         out_enable,
    output logic                        pump_output,
    output logic                        osc_enable,
    output logic                        drivers_ready,
    output logic                        global_fault_summary,
    output logic                        supply_undervoltage_flag,
    output logic                        supply_overvoltage_flag,
    output logic [`NUM_OUT-1:0]         overcurrent_flag
);
    import pwm_ctrl_pkg::*;

    localparam int NUM_OC_SYNC = `NUM_OUT;
    // Pin sync (3) and enable register (1) eat into the 400 us budget
    localparam logic [`ACT_CNT_W-1:0] ACT_TOP =
        `ACT_CNT_W'(`ACT_DELAY_CYC - 6);

    typedef struct packed {
        logic [1:0]             uv_sync;
        logic [1:0]             ov_sync;
        logic [1:0]             pa_sync;
        logic [1:0]             pb_sync;
        logic [1:0]             cs_sync;
        logic [NUM_OC_SYNC-1:0] oc_sync1;
        logic [NUM_OC_SYNC-1:0] oc_sync2;
        logic                   cs_prev;
        mode_state_t            mode;
        logic [`ACT_CNT_W-1:0]  act_cnt;
        logic                   uv_flag;
        logic                   ov_flag;
        logic                   hold_off;
        logic [`NUM_OUT-1:0]    drive;
        logic [`NUM_OUT-1:0]    enable;
    } ctl_t;

    ctl_t s_q;
    ctl_t s_d;
    logic [`NUM_OUT-1:0]  allow;
    logic [`NUM_LAMP-1:0] gen_pwm;
    logic [`NUM_OUT-1:0]  pwm_sel;
    logic                 supply_bad;
    logic                 cs_rise;

    // Per-output overcurrent handling and lamp generators
    genvar i;
    generate
        for (i = 0; i < `NUM_OUT; i++)
        begin : g_out
            logic [`REC_CNT_W-1:0] rec_cyc;
            logic                  bulb;
            // Only the first two lamps have a bulb mode
            assign bulb = (i == `LAMP_BASE || i == `LAMP_BASE + 1)
                && !lamp_led_mode[(i - `LAMP_BASE) & 3];
            assign rec_cyc = bulb ? `REC_CNT_W'(`REC_BULB_CYC)
                : recovery_slow_select[i] ? `REC_CNT_W'(`REC_SLOW_CYC)
                : `REC_CNT_W'(`REC_FAST_CYC);
            oc_retry u_oc
            (
                .mclk                     (mclk),
                .rst                      (rst),
                .overcurrent              (s_q.oc_sync2[i]),
                .overcurrent_retry_enable (overcurrent_retry_enable[i]),
                .fault_clear              (oc_status_clear[i]),
                .recovery_cycles          (rec_cyc),
                .out_allow                (allow[i]),
                .oc_flag                  (overcurrent_flag[i])
            );
            if (i >= `LAMP_BASE && i < `LAMP_BASE + `NUM_LAMP)
            begin : g_lamp
                lamp_pwm_gen u_gen
                (
                    .mclk                   (mclk),
                    .rst                    (rst),
                    .run                    (s_q.mode == ST_ACTIVE),
                    .pwm_frequency_select
                        (pwm_frequency_select[i-`LAMP_BASE]),
                    .duty_resolution_select (duty_resolution_select),
                    .duty_value             (duty_value[i-`LAMP_BASE]),
                    .pwm_out                (gen_pwm[i-`LAMP_BASE])
                );
                // Odd lamps (even index) on pin a, even lamps on pin b
                assign pwm_sel[i] = pwm_source_internal_select
                    ? gen_pwm[i-`LAMP_BASE]
                    : (((i - `LAMP_BASE) % 2) == 1)
                        ? s_q.pb_sync[1]
                        : s_q.pa_sync[1];
            end
            else
            begin : g_ext
                assign pwm_sel[i] = s_q.pa_sync[1];
            end
        end
    endgenerate

    always_comb
    begin
        s_d = s_q;
        s_d.uv_sync  = {s_q.uv_sync[0], supply_uv_in};
        s_d.ov_sync  = {s_q.ov_sync[0], supply_ov_in};
        s_d.pa_sync  = {s_q.pa_sync[0], pwm_input_a};
        s_d.pb_sync  = {s_q.pb_sync[0], sense_out_pwm_input_b};
        s_d.cs_sync  = {s_q.cs_sync[0], chip_select_n};
        s_d.oc_sync1 = overcurrent_in;
        s_d.oc_sync2 = s_q.oc_sync1;
        s_d.cs_prev  = s_q.cs_sync[1];
        cs_rise    = s_q.cs_sync[1] && !s_q.cs_prev;
        supply_bad = s_q.uv_sync[1] || s_q.ov_sync[1];

        // Supply flags: set wins over read-and-clear
        if (status2_read_clear)
        begin
            s_d.uv_flag = 1'b0;
            s_d.ov_flag = 1'b0;
        end
        if (s_q.uv_sync[1])
            s_d.uv_flag = 1'b1;
        if (s_q.ov_sync[1])
            s_d.ov_flag = 1'b1;

        // Lockout holds until supply good and, if latched, flags cleared
        if (supply_bad)
            s_d.hold_off = 1'b1;
        else if (!supply_fault_latch_select)
            s_d.hold_off = 1'b0;
        else if (!s_q.uv_flag && !s_q.ov_flag)
            s_d.hold_off = 1'b0;

        // Mode sequencing; delay starts at chip select release
        case (s_q.mode)
            ST_STANDBY:
                if (mode_active && cs_rise)
                begin
                    s_d.mode    = ST_WAKE;
                    s_d.act_cnt = '0;
                end
            ST_WAKE:
                if (!mode_active)
                    s_d.mode = ST_STANDBY;
                else if (s_q.act_cnt >= ACT_TOP)
                    s_d.mode = ST_ACTIVE;
                else
                    s_d.act_cnt = s_q.act_cnt + `ACT_CNT_W'(1);
            ST_ACTIVE:
                if (!mode_active && cs_rise)
                    s_d.mode = ST_STANDBY;
            default:
                s_d.mode = ST_STANDBY;
        endcase

        for (int k = 0; k < `NUM_OUT; k++)
        begin
            s_d.drive[k] = out_on[k]
                && (!output_pwm_enable[k] || pwm_sel[k]);
            s_d.enable[k] = (s_d.mode == ST_ACTIVE) && !s_q.hold_off
                && !supply_bad && allow[k];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_q          <= '0;
            s_q.mode     <= ST_STANDBY;
            s_q.cs_sync  <= 2'h3;
            s_q.cs_prev  <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Control state lives on the logic supply only
    assign out_drive                = s_q.drive & s_q.enable;
    assign out_enable               = s_q.enable;
    assign osc_enable               = s_q.mode != ST_STANDBY;
    assign pump_output              = s_q.mode != ST_STANDBY;
    assign drivers_ready            = s_q.mode == ST_ACTIVE;
    assign supply_undervoltage_flag = s_q.uv_flag;
    assign supply_overvoltage_flag  = s_q.ov_flag;
    assign global_fault_summary     = s_q.uv_flag || s_q.ov_flag
        || (|overcurrent_flag);
endmodule // output_pwm_ctrl

// ==== pkg/pwm_ctrl_params.svh ====
`ifndef PWM_CTRL_PARAMS_SVH
`define PWM_CTRL_PARAMS_SVH

// Output population
`define NUM_OUT        9
`define NUM_LAMP       4
`define LAMP_BASE      4
// Clock and timing
`define MCLK_HZ        100000000
`define ACT_DELAY_US   400
`define ACT_DELAY_CYC  ((`ACT_DELAY_US * (`MCLK_HZ / 1000000)))
// Internal PWM period: 1024 steps per period
`define PWM_STEPS      1024
`define FREQ_LO_HZ     170
`define FREQ_HI_HZ     225
`define TICK_LO_CYC    (`MCLK_HZ / (`FREQ_LO_HZ * `PWM_STEPS))
`define TICK_HI_CYC    (`MCLK_HZ / (`FREQ_HI_HZ * `PWM_STEPS))
// Overcurrent recovery times
`define REC_FAST_US    500
`define REC_SLOW_US    2000
`define REC_BULB_US    1000
`define REC_FAST_CYC   (`REC_FAST_US * (`MCLK_HZ / 1000000))
`define REC_SLOW_CYC   (`REC_SLOW_US * (`MCLK_HZ / 1000000))
`define REC_BULB_CYC   (`REC_BULB_US * (`MCLK_HZ / 1000000))
`define REC_CNT_W      18
`define ACT_CNT_W      16
`define TICK_CNT_W     10
// Reset values
`define PWM_SRC_RST    1'b0

`endif

// ==== pkg/pwm_ctrl_pkg.sv ====
package pwm_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_WAKE,
        ST_ACTIVE
    } mode_state_t;

    typedef enum logic [1:0] {
        OC_RUN,
        OC_WAIT,
        OC_LATCHED
    } oc_state_t;

    typedef logic [9:0] duty_t;
endpackage

// ==== rtl/lamp_pwm_gen.sv ====
`timescale 1ns/100ps
`include "pwm_ctrl_params.svh"
module lamp_pwm_gen
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // Settings
    input  wire logic                 run,
    input  wire logic                 pwm_frequency_select,
    input  wire logic                 duty_resolution_select,
    input  wire pwm_ctrl_pkg::duty_t  duty_value,
    // Result
    output logic                      pwm_out
);
    import pwm_ctrl_pkg::*;

    typedef struct packed {
        logic [`TICK_CNT_W-1:0] tick;
        logic [9:0]             phase;
        logic                   out;
    } gen_t;

    gen_t s_q;
    gen_t s_d;
    logic [`TICK_CNT_W-1:0] tick_top;
    logic [9:0]             duty_eff;

    always_comb
    begin
        s_d = s_q;
        tick_top = pwm_frequency_select
            ? `TICK_CNT_W'(`TICK_HI_CYC - 1)
            : `TICK_CNT_W'(`TICK_LO_CYC - 1);
        // 7-bit duty is scaled onto the same 1024-step period
        duty_eff = duty_resolution_select ? duty_value
                                          : {duty_value[6:0], 3'h0};
        if (!run)
        begin
            s_d = '0;
        end
        else if (s_q.tick >= tick_top)
        begin
            s_d.tick  = '0;
            s_d.phase = s_q.phase + 10'h001;
        end
        else
        begin
            s_d.tick = s_q.tick + `TICK_CNT_W'(1);
        end
        s_d.out = run && (s_q.phase < duty_eff);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign pwm_out = s_q.out;
endmodule // lamp_pwm_gen

// ==== rtl/oc_retry.sv ====
`timescale 1ns/100ps
`include "pwm_ctrl_params.svh"
module oc_retry
(
    // Clock and reset
    input  wire logic   mclk,
    input  wire logic   rst,
    // Control
    input  wire logic   overcurrent,
    input  wire logic   overcurrent_retry_enable,
    input  wire logic   fault_clear,
    input  wire logic [`REC_CNT_W-1:0] recovery_cycles,
    // Status
    output logic        out_allow,
    output logic        oc_flag
);
    import pwm_ctrl_pkg::*;

    typedef struct packed {
        oc_state_t              st;
        logic [`REC_CNT_W-1:0]  cnt;
        logic                   flag;
    } oc_t;

    oc_t s_q;
    oc_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (fault_clear)
            s_d.flag = 1'b0;
        if (overcurrent)
            s_d.flag = 1'b1; // Set beats clear
        case (s_q.st)
            OC_RUN:
                if (overcurrent)
                begin
                    s_d.cnt = '0;
                    s_d.st  = overcurrent_retry_enable ? OC_WAIT
                                                       : OC_LATCHED;
                end
            OC_WAIT:
                if (!overcurrent_retry_enable)
                    s_d.st = OC_LATCHED;
                else if (s_q.cnt >= recovery_cycles)
                    s_d.st = OC_RUN;
                else
                    s_d.cnt = s_q.cnt + `REC_CNT_W'(1);
            OC_LATCHED:
                if (fault_clear && !overcurrent)
                    s_d.st = OC_RUN;
            default:
                s_d.st = OC_RUN;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s_q <= '{st: OC_RUN, cnt: '0, flag: 1'b0};
        else
            s_q <= s_d;
    end

    assign out_allow = (s_q.st == OC_RUN) && !overcurrent;
    assign oc_flag   = s_q.flag;
endmodule // oc_retry

// ==== verification/output_pwm_ctrl_props.sv ====
`timescale 1ns/100ps
`include "pwm_ctrl_params.svh"
module output_pwm_ctrl_props
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // Watched inputs
    input  wire logic                 supply_uv_in,
    input  wire logic                 status2_read_clear,
    input  wire logic                 supply_fault_latch_select,
    input  wire logic [`NUM_OUT-1:0]  overcurrent_retry_enable,
    // Watched outputs
    input  wire logic [`NUM_OUT-1:0]  out_drive,
    input  wire logic [`NUM_OUT-1:0]  out_enable,
    input  wire logic                 pump_output,
    input  wire logic                 osc_enable,
    input  wire logic                 drivers_ready,
    input  wire logic                 global_fault_summary,
    input  wire logic                 supply_undervoltage_flag,
    input  wire logic                 supply_overvoltage_flag,
    input  wire logic [`NUM_OUT-1:0]  overcurrent_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Counts pump-on cycles still waiting for the drivers
    logic [16:0] wake_q;
    logic [16:0] wake_d;
    logic [`NUM_OUT-1:0] oc_lock;
    assign oc_lock = overcurrent_flag & ~overcurrent_retry_enable;
    always_comb
    begin
        wake_d = (pump_output && !drivers_ready) ? wake_q + 17'h1 : 17'h0;
    end
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            wake_q <= 17'h0;
        else
            wake_q <= wake_d;
    end
    chk_summary_or: assert property (global_fault_summary ==
        (supply_undervoltage_flag | supply_overvoltage_flag | (|overcurrent_flag)))
        else $error("fault summary differs from its sources");
    chk_uv_flag_set: assert property (supply_uv_in [*5]
        |-> supply_undervoltage_flag) else $error("undervoltage flag not set");
    chk_uv_hiz: assert property (supply_uv_in [*5]
        |-> out_enable == '0 && out_drive == '0)
        else $error("outputs not released on undervoltage");
    chk_uv_sticky: assert property (supply_undervoltage_flag
        && !status2_read_clear |=> supply_undervoltage_flag)
        else $error("undervoltage flag dropped without clear");
    chk_ov_sticky: assert property (supply_overvoltage_flag
        && !status2_read_clear |=> supply_overvoltage_flag)
        else $error("overvoltage flag dropped without clear");
    chk_pump_mode: assert property (drivers_ready
        |-> pump_output && osc_enable) else $error("pump off while ready");
    chk_ready_delay: assert property ($rose(drivers_ready)
        |-> wake_q >= 17'd39990 && wake_q <= 17'd39996)
        else $error("activation delay out of range");
    chk_enable_ready: assert property ((|out_enable)
        |-> drivers_ready) else $error("driver enabled before ready");
    chk_latched_off: assert property (supply_fault_latch_select
        && supply_undervoltage_flag |-> out_enable == '0)
        else $error("latched supply fault released early");
    chk_oc_kept_off: assert property (((oc_lock & $past(oc_lock))
        & out_drive) == '0) else $error("latched overcurrent output driven");
    cov_ready: cover property ($rose(drivers_ready));
    cov_uv_latched: cover property ($rose(supply_undervoltage_flag)
        && supply_fault_latch_select);
    cov_oc: cover property ($rose(|overcurrent_flag));
endmodule // output_pwm_ctrl_props

bind output_pwm_ctrl output_pwm_ctrl_props chk (.mclk, .rst, .supply_uv_in,
    .status2_read_clear, .supply_fault_latch_select,
    .overcurrent_retry_enable, .out_drive, .out_enable, .pump_output,
    .osc_enable, .drivers_ready, .global_fault_summary,
    .supply_undervoltage_flag, .supply_overvoltage_flag, .overcurrent_flag);

// ==== verification/mcu_link_model.sv ====
`timescale 1ns/100ps
module mcu_link_model
(
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  rst,
    // Requests from the bench
    input  wire logic  frame,
    input  wire logic  want,
    input  wire logic  lvl_a,
    input  wire logic  lvl_b,
    // Pins toward the device
    output logic       chip_select_n,
    output logic       mode_active,
    output logic       pwm_input_a,
    output logic       sense_out_pwm_input_b
);
    logic [2:0] low_q;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            low_q <= 3'h0;
            chip_select_n <= 1'b1;
            mode_active <= 1'b0;
            pwm_input_a <= 1'b0;
            sense_out_pwm_input_b <= 1'b0;
        end
        else
        begin
            if (frame)
                low_q <= 3'h4;
            else if (low_q != 3'h0)
                low_q <= low_q - 3'h1;
            // Mode bit stands before select rises again
            chip_select_n <= !(frame || low_q > 3'h1);
            if (frame)
                mode_active <= want;
            pwm_input_a <= lvl_a;
            sense_out_pwm_input_b <= lvl_b;
        end
    end
endmodule // mcu_link_model

// ==== verification/output_pwm_ctrl_tb.sv ====
`timescale 1ns/100ps
module output_pwm_ctrl_tb;
    import pwm_ctrl_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        cs_n, mode, pin_a, pin_b, frame, want, pa, pb;
    logic        latch, s2clr, uv, ov, isel, res;
    logic [8:0]  on, pen, ocr, occlr, oc, drv, oen, ocf;
    logic [3:0]  fsel;
    duty_t       duty [4];
    logic        pump, osc, rdy, sum, uvf, ovf;
    logic [31:0] seed = 32'd70665;
    logic [31:0] v;
    int          miscompares = 0;
    int          n_tests = 0;
    int          k;
    always #5 mclk = ~mclk;
    mcu_link_model mcu (.mclk, .rst, .frame, .want, .lvl_a(pa), .lvl_b(pb),
        .chip_select_n(cs_n), .mode_active(mode), .pwm_input_a(pin_a),
        .sense_out_pwm_input_b(pin_b));
    output_pwm_ctrl dut (.mclk, .rst, .chip_select_n(cs_n),
        .mode_active(mode), .supply_fault_latch_select(latch),
        .status2_read_clear(s2clr), .supply_uv_in(uv), .supply_ov_in(ov),
        .pwm_input_a(pin_a), .sense_out_pwm_input_b(pin_b), .out_on(on),
        .output_pwm_enable(pen), .overcurrent_retry_enable(ocr),
        .recovery_slow_select(9'h0), .oc_status_clear(occlr),
        .overcurrent_in(oc), .pwm_source_internal_select(isel),
        .duty_resolution_select(res), .pwm_frequency_select(fsel),
        .lamp_led_mode(4'h0), .duty_value(duty), .out_drive(drv),
        .out_enable(oen), .pump_output(pump), .osc_enable(osc),
        .drivers_ready(rdy), .global_fault_summary(sum),
        .supply_undervoltage_flag(uvf), .supply_overvoltage_flag(ovf),
        .overcurrent_flag(ocf));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Even lamps follow pin b, all others pin a
    function automatic logic [8:0] exp_drv(input logic [8:0] o, e,
                                           input logic a, b);
        logic [8:0] r;
        for (int i = 0; i < 9; i++)
            r[i] = o[i] & (~e[i] | ((i == 5 || i == 7) ? b : a));
        return r;
    endfunction
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask
    // Lets the edge's updates land before sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic clr(input logic s, input logic [8:0] m);
        @(posedge mclk);
        s2clr <= s;
        occlr <= m;
        @(posedge mclk);
        s2clr <= 1'b0;
        occlr <= 9'h0;
        cyc(4);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        {frame, want, pa, pb, latch, s2clr, uv, ov, isel, res} = '0;
        {on, pen, ocr, occlr, oc, fsel} = '0;
        foreach (duty[i]) duty[i] = 10'h0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        cyc(2);
        chk(pump, 0);
        chk(oen, 0);
        chk(sum, 0);
        $display("reset test done");
        @(posedge mclk);
        on <= 9'h1FF;
        want <= 1'b1;
        frame <= 1'b1;
        @(posedge mclk);
        frame <= 1'b0;
        k = 0;
        while ((cs_n !== 1'b1 || k == 0) && k < 20)
        begin
            cyc(1);
            k++;
        end
        for (k = 0; rdy !== 1'b1 && k < 41000; k++)
        begin
            cyc(1);
            if (k == 20000)
            begin
                chk({pump, osc, oen}, {2'b11, 9'h0});
            end
        end
        if (k >= 41000)
        begin
            miscompares++;
            tally_and_finish;
        end
        chk(k >= 39990 && k <= 39999, 1);
        $display("activation test done");
        for (int t = 0; t < 24; t++)
        begin
            seed = xs(seed);
            v = (t == 0) ? 32'h0007FFFF : (t == 1) ? 32'h000BFFFF : seed;
            @(posedge mclk);
            on <= v[8:0];
            pen <= v[17:9];
            pa <= v[18];
            pb <= v[19];
            cyc(8);
            chk(drv, exp_drv(v[8:0], v[17:9], v[18], v[19]));
        end
        $display("external pwm test done");
        @(posedge mclk);
        {on, pen, pa, pb, isel} <= {9'h1FF, 9'h1FF, 3'b111};
        for (int t = 0; t < 4; t++)
        begin
            @(posedge mclk);
            res <= t[0];
            fsel <= {4{t[1]}};
            cyc(20);
            chk(drv, 9'h10F);
        end
        @(posedge mclk);
        {pen, isel, ocr} <= {9'h0, 1'b0, 9'h002};
        oc <= 9'h003;
        cyc(6);
        chk({ocf[0], drv[0], sum}, 3'b101);
        @(posedge mclk);
        ocr <= 9'h0;
        cyc(6);
        @(posedge mclk);
        oc <= 9'h0;
        cyc(6);
        chk(drv[1:0], 2'b00);
        clr(1'b0, 9'h003);
        chk({ocf, drv}, {9'h0, 9'h1FF});
        $display("overcurrent test done");
        @(posedge mclk);
        uv <= 1'b1;
        cyc(6);
        chk({uvf, sum, oen, drv}, {2'b11, 18'h0});
        @(posedge mclk);
        uv <= 1'b0;
        cyc(6);
        chk({uvf, drv}, {1'b1, 9'h1FF});
        clr(1'b1, 9'h0);
        chk(uvf, 0);
        @(posedge mclk);
        latch <= 1'b1;
        uv <= 1'b1;
        cyc(6);
        @(posedge mclk);
        uv <= 1'b0;
        cyc(10);
        chk(drv, 9'h0);
        clr(1'b1, 9'h0);
        chk(drv, 9'h1FF);
        $display("undervoltage test done");
        @(posedge mclk);
        ov <= 1'b1;
        cyc(6);
        chk({ovf, sum}, 2'b11);
        @(posedge mclk);
        ov <= 1'b0;
        cyc(4);
        clr(1'b1, 9'h0);
        chk(ovf, 0);
        $display("overvoltage test done");
        @(posedge mclk);
        want <= 1'b0;
        frame <= 1'b1;
        @(posedge mclk);
        frame <= 1'b0;
        for (k = 0; pump !== 1'b0 && k < 200; k++)
            cyc(1);
        chk(pump, 0);
        $display("standby test done");
        tally_and_finish;
    end
endmodule // output_pwm_ctrl_tb
